/* File: include/serial_flash_consts.vh */
// Opcodes, phase codes and field positions of the serial flash command port
`ifndef SERIAL_FLASH_CONSTS_VH
`define SERIAL_FLASH_CONSTS_VH
// ==========================================================
// Opcodes
`define OP_READ 8'h03
`define OP_FREAD 8'h0B
`define OP_DREAD 8'h3B
`define OP_DIOREAD 8'hBB
`define OP_SSE_A 8'h20
`define OP_SSE_B 8'hD7
`define OP_SE 8'hD8
`define OP_CE_A 8'h60
`define OP_CE_B 8'hC7
`define OP_PP 8'h02
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PDOWN 8'hB9
`define OP_RDSR 8'h05
`define OP_WRSR 8'h01
`define OP_JID 8'h9F
`define OP_RDID 8'hAB
// ==========================================================
// Command phases
`define PH_IDLE 3'h0
`define PH_CMD 3'h1
`define PH_ADDR 3'h2
`define PH_DUMMY 3'h3
`define PH_DOUT 3'h4
`define PH_DIN 3'h5
`define PH_SRW 3'h6
`define PH_IGN 3'h7
// ==========================================================
// Output byte sources
`define SRC_MEM 2'h0
`define SRC_STAT 2'h1
`define SRC_JID 2'h2
`define SRC_ID 2'h3
// ==========================================================
// Status byte fields and reset values
`define ST_LOCK 7
`define ST_BP_HI 5
`define ST_BP_LO 2
`define ST_WEL 1
`define ST_BUSY 0
`define BP_RST 4'h0
`define LOCK_RST 1'b0
`define BITS_PER_BYTE 4'h8
`define ADDR_LAST_BYTE 2'h2
`endif

/* File: hdl/serial_flash_command_port.v */
// Serial flash command port with program data FIFO
`timescale 1ns/1ps
`include "serial_flash_consts.vh"

// ==========================================================
// Program data FIFO
module prog_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
)(
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_ptr_reg];
  always @(posedge sys_clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// ==========================================================
// Command port
module serial_flash_command_port #(
  parameter ADDR_W = 19,
  parameter FIFO_DEPTH = 32,
  parameter [7:0] MFR_ID = 8'h5A,
  parameter [15:0] DEV_ID = 16'hA512
)(
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire sck_i,
  input wire cs_n_i,
  input wire data_line_zero_i,
  output wire data_line_zero_o,
  output wire data_line_zero_oe_o,
  input wire data_line_one_i,
  output wire data_line_one_o,
  output wire data_line_one_oe_o,
  input wire wp_n_i,
  input wire hold_n_i,
  input wire busy_i,
  input wire [7:0] mem_rdata_i,
  output wire mem_rd_o,
  output wire [ADDR_W-1:0] mem_addr_o,
  output wire small_erase_o,
  output wire sector_erase_o,
  output wire chip_erase_o,
  output wire [7:0] program_data_bytes_o,
  output wire prog_valid_o,
  input wire prog_ready_i,
  output wire prog_overflow_o,
  output wire selected_o,
  output wire spi_mode3_o,
  output wire power_down_o,
  output wire [7:0] status_o
);
  // ==========================================================
  // Pin synchronisers
  reg sck_m, sck_s, sck_d, cs_m, cs_s, cs_d;
  reg io0_m, io0_s, io1_m, io1_s, wp_m, wp_s, hold_m, hold_s;
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      {sck_m, sck_s, sck_d} <= 3'h0;
      {cs_m, cs_s, cs_d} <= 3'h7;
      {io0_m, io0_s, io1_m, io1_s} <= 4'h0;
      {wp_m, wp_s, hold_m, hold_s} <= 4'hF;
    end
    else
    begin
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_d <= sck_s;
      cs_m <= cs_n_i;
      cs_s <= cs_m;
      cs_d <= cs_s;
      io0_m <= data_line_zero_i;
      io0_s <= io0_m;
      io1_m <= data_line_one_i;
      io1_s <= io1_m;
      wp_m <= wp_n_i;
      wp_s <= wp_m;
      hold_m <= hold_n_i;
      hold_s <= hold_m;
    end
  end
  wire active = ~cs_s & ~cs_d & hold_s;
  wire sck_rise = active & sck_s & ~sck_d;
  wire sck_fall = active & ~sck_s & sck_d;
  wire cs_fall = ~cs_s & cs_d;
  wire cs_rise = cs_s & ~cs_d;

  // ==========================================================
  // State
  reg [2:0] phase_reg;
  reg [7:0] op_reg;
  reg [7:0] in_sh_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [ADDR_W-1:0] addr_reg;
  reg [7:0] out_sh_reg;
  reg [3:0] out_cnt_reg;
  reg [1:0] src_reg;
  reg [1:0] jid_idx_reg;
  reg dual_in_reg, dual_out_reg, load_reg, oe_reg;
  reg io0_reg, io1_reg, mode3_reg, wel_reg, pd_reg, lock_reg;
  reg [3:0] bp_reg;
  reg sse_reg, se_reg, ce_reg, push_reg, ovf_reg;
  reg [7:0] push_data_reg;
  wire fifo_in_ready;

  // Dual capture puts the odd bit first: line 1 holds A23, A21 ...
  wire [7:0] in_byte = dual_in_reg ? {in_sh_reg[5:0], io1_s, io0_s}
    : {in_sh_reg[6:0], io0_s};
  wire [3:0] bit_next = bit_cnt_reg + (dual_in_reg ? 4'h2 : 4'h1);
  wire byte_done = sck_rise & (bit_next == `BITS_PER_BYTE);
  wire [ADDR_W-1:0] addr_next = {addr_reg[ADDR_W-9:0], in_byte};
  wire [7:0] status_byte = {lock_reg, 1'b0, bp_reg, wel_reg, busy_i};
  wire protect = ~wp_s & lock_reg;
  reg [7:0] src_byte;
  always @*
  begin
    case (src_reg)
      `SRC_MEM: src_byte = mem_rdata_i;
      `SRC_STAT: src_byte = status_byte;
      `SRC_JID: src_byte = (jid_idx_reg == 2'h0) ? MFR_ID
        : (jid_idx_reg == 2'h1) ? DEV_ID[15:8] : DEV_ID[7:0];
      default: src_byte = DEV_ID[7:0];
    endcase
  end

  // ==========================================================
  // Command sequencer
  always @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      phase_reg <= `PH_IDLE;
      op_reg <= 8'h00;
      in_sh_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 2'h0;
      addr_reg <= {ADDR_W{1'b0}};
      out_sh_reg <= 8'h00;
      out_cnt_reg <= 4'h0;
      src_reg <= `SRC_MEM;
      jid_idx_reg <= 2'h0;
      {dual_in_reg, dual_out_reg, load_reg, oe_reg} <= 4'h0;
      {io0_reg, io1_reg, mode3_reg, wel_reg, pd_reg} <= 5'h0;
      lock_reg <= `LOCK_RST;
      bp_reg <= `BP_RST;
      {sse_reg, se_reg, ce_reg, push_reg, ovf_reg} <= 5'h0;
      push_data_reg <= 8'h00;
    end
    else
    begin
      {sse_reg, se_reg, ce_reg, push_reg, load_reg} <= 5'h0;
      if (load_reg)
      begin
        out_sh_reg <= src_byte;
        out_cnt_reg <= 4'h0;
      end
      if (push_reg & ~fifo_in_ready)
        ovf_reg <= 1'b1;
      if (cs_rise)
      begin
        phase_reg <= `PH_IDLE;
        {dual_in_reg, dual_out_reg, oe_reg} <= 3'h0;
      end
      else if (cs_fall)
      begin
        phase_reg <= `PH_CMD;
        mode3_reg <= sck_s;
        bit_cnt_reg <= 4'h0;
        byte_cnt_reg <= 2'h0;
        jid_idx_reg <= 2'h0;
        // A loss in the same cycle as the new select still shows
        ovf_reg <= push_reg & ~fifo_in_ready;
        {dual_in_reg, dual_out_reg, oe_reg} <= 3'h0;
      end
      else
      begin
        if (sck_rise)
        begin
          in_sh_reg <= in_byte;
          bit_cnt_reg <= byte_done ? 4'h0 : bit_next;
        end
        if (byte_done)
        begin
          case (phase_reg)
            `PH_CMD:
            begin
              op_reg <= in_byte;
              phase_reg <= `PH_IGN;
              if (in_byte == `OP_RDID)
              begin
                pd_reg <= 1'b0;
                phase_reg <= `PH_ADDR;
              end
              else if (~pd_reg)
              begin
                case (in_byte)
                  `OP_READ, `OP_FREAD, `OP_DREAD, `OP_PP,
                  `OP_SSE_A, `OP_SSE_B, `OP_SE: phase_reg <= `PH_ADDR;
                  `OP_DIOREAD:
                  begin
                    phase_reg <= `PH_ADDR;
                    dual_in_reg <= 1'b1;
                  end
                  `OP_CE_A, `OP_CE_B:
                  begin
                    ce_reg <= wel_reg;
                    wel_reg <= 1'b0;
                  end
                  `OP_WREN: wel_reg <= 1'b1;
                  `OP_WRDI: wel_reg <= 1'b0;
                  `OP_PDOWN: pd_reg <= 1'b1;
                  `OP_RDSR:
                  begin
                    phase_reg <= `PH_DOUT;
                    src_reg <= `SRC_STAT;
                    load_reg <= 1'b1;
                  end
                  `OP_WRSR: phase_reg <= `PH_SRW;
                  `OP_JID:
                  begin
                    phase_reg <= `PH_DOUT;
                    src_reg <= `SRC_JID;
                    load_reg <= 1'b1;
                  end
                  default: phase_reg <= `PH_IGN;
                endcase
              end
            end
            `PH_ADDR:
            begin
              addr_reg <= addr_next;
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
              if (byte_cnt_reg == `ADDR_LAST_BYTE)
              begin
                phase_reg <= `PH_IGN;
                case (op_reg)
                  `OP_READ:
                  begin
                    phase_reg <= `PH_DOUT;
                    src_reg <= `SRC_MEM;
                    load_reg <= 1'b1;
                  end
                  `OP_FREAD, `OP_DREAD, `OP_DIOREAD: phase_reg <= `PH_DUMMY;
                  `OP_RDID:
                  begin
                    phase_reg <= `PH_DOUT;
                    src_reg <= `SRC_ID;
                    load_reg <= 1'b1;
                  end
                  `OP_PP:
                  begin
                    if (wel_reg)
                      phase_reg <= `PH_DIN;
                    wel_reg <= 1'b0;
                  end
                  `OP_SE:
                  begin
                    se_reg <= wel_reg;
                    wel_reg <= 1'b0;
                  end
                  default:
                  begin
                    sse_reg <= wel_reg;
                    wel_reg <= 1'b0;
                  end
                endcase
              end
            end
            `PH_DUMMY:
            begin
              // Lines stay released through the dummy byte for bus turnaround
              phase_reg <= `PH_DOUT;
              src_reg <= `SRC_MEM;
              load_reg <= 1'b1;
              dual_in_reg <= 1'b0;
              dual_out_reg <= (op_reg != `OP_FREAD);
            end
            `PH_DIN:
            begin
              push_reg <= 1'b1;
              push_data_reg <= in_byte;
            end
            `PH_SRW:
            begin
              if (wel_reg & ~protect)
              begin
                lock_reg <= in_byte[`ST_LOCK];
                bp_reg <= in_byte[`ST_BP_HI:`ST_BP_LO];
                wel_reg <= 1'b0;
              end
              phase_reg <= `PH_IGN;
            end
            default: phase_reg <= phase_reg;
          endcase
        end
        if (sck_fall && phase_reg == `PH_DOUT)
        begin
          oe_reg <= 1'b1;
          if (dual_out_reg)
          begin
            io0_reg <= out_sh_reg[7];
            io1_reg <= out_sh_reg[6];
            out_sh_reg <= {out_sh_reg[5:0], 2'b00};
          end
          else
          begin
            io1_reg <= out_sh_reg[7];
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
          end
          out_cnt_reg <= out_cnt_reg + (dual_out_reg ? 4'h2 : 4'h1);
          if (out_cnt_reg + (dual_out_reg ? 4'h2 : 4'h1) == `BITS_PER_BYTE)
          begin
            addr_reg <= addr_reg + 1'b1;
            jid_idx_reg <= (jid_idx_reg == 2'h2) ? 2'h0 : jid_idx_reg + 2'h1;
            load_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // FIFO toward the array; a full FIFO loses the byte and flags it
  prog_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(push_data_reg),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .out_data_o(program_data_bytes_o),
    .out_valid_o(prog_valid_o),
    .out_ready_i(prog_ready_i)
  );

  // ==========================================================
  // Outputs
  wire drive = oe_reg & ~cs_s & hold_s;
  assign data_line_zero_o = io0_reg;
  assign data_line_zero_oe_o = drive & dual_out_reg;
  assign data_line_one_o = io1_reg;
  assign data_line_one_oe_o = drive;
  assign mem_rd_o = load_reg & (src_reg == `SRC_MEM);
  assign mem_addr_o = addr_reg;
  assign small_erase_o = sse_reg;
  assign sector_erase_o = se_reg;
  assign chip_erase_o = ce_reg;
  assign prog_overflow_o = ovf_reg;
  assign selected_o = ~cs_s;
  assign spi_mode3_o = mode3_reg;
  assign power_down_o = pd_reg;
  assign status_o = status_byte;
endmodule

/* File: verification/flash_port_checker_assertions.sv */
// Checker for the serial flash command port pins
`timescale 1ns/1ps
module flash_port_checker (
  input wire sys_clk_i,
  input wire sys_rst_i,
  input wire sck_i,
  input wire hold_n_i,
  input wire busy_i,
  input wire data_line_zero_o,
  input wire data_line_zero_oe_o,
  input wire data_line_one_o,
  input wire data_line_one_oe_o,
  input wire mem_rd_o,
  input wire small_erase_o,
  input wire sector_erase_o,
  input wire chip_erase_o,
  input wire [7:0] program_data_bytes_o,
  input wire prog_valid_o,
  input wire prog_ready_i,
  input wire selected_o,
  input wire spi_mode3_o,
  input wire [7:0] status_o
);
  // ==========================================================
  // Pin properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_OE_IDLE: assert property ((!selected_o)[*3] |->
    !data_line_zero_oe_o && !data_line_one_oe_o) else $error("driven while deselected");
  AST_HOLD_OE: assert property ((!hold_n_i)[*5] |->
    !data_line_zero_oe_o && !data_line_one_oe_o) else $error("driven during hold");
  AST_OE_PAIR: assert property (data_line_zero_oe_o |-> data_line_one_oe_o)
    else $error("line zero driven alone");
  AST_OUT_HOLD: assert property ((selected_o && sck_i && hold_n_i)[*6] |->
    $stable(data_line_one_o) && $stable(data_line_zero_o)) else $error("output moved");
  AST_RD_PULSE: assert property (mem_rd_o |=> (!mem_rd_o)[*8])
    else $error("array reads too close");
  AST_ERASE: assert property (small_erase_o |-> !sector_erase_o && !chip_erase_o ##1
    !small_erase_o) else $error("erase pulse wrong");
  AST_STATUS: assert property (status_o[0] == busy_i && !status_o[6])
    else $error("status bits wrong");
  AST_MODE: assert property (selected_o && $past(selected_o) && $past(selected_o, 2) &&
    $past(selected_o, 3) |-> $stable(spi_mode3_o)) else $error("mode moved while selected");
  AST_FIFO: assert property (prog_valid_o && !prog_ready_i |=> prog_valid_o &&
    $stable(program_data_bytes_o)) else $error("stalled head moved");
endmodule
bind serial_flash_command_port flash_port_checker i_flash_port_checker (
  .sys_clk_i, .sys_rst_i, .sck_i, .hold_n_i, .busy_i, .data_line_zero_o, .data_line_zero_oe_o,
  .data_line_one_o, .data_line_one_oe_o, .mem_rd_o, .small_erase_o, .sector_erase_o,
  .chip_erase_o, .program_data_bytes_o, .prog_valid_o, .prog_ready_i, .selected_o,
  .spi_mode3_o, .status_o);

/* File: verification/flash_host.sv */
// Host controller model driving the serial pins
`timescale 1ns/1ps
module flash_host (
  input wire sys_clk_i,
  input wire line0_i,
  input wire line1_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic d0_o,
  output logic d1_o,
  output logic oe0_o,
  output logic oe1_o
);
  logic m3_reg = 1'b0;
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    d0_o = 1'b0;
    d1_o = 1'b0;
    oe0_o = 1'b0;
    oe1_o = 1'b0;
  end
  // ==========================================================
  // Link timing, 200 ns serial period
  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic start(input logic m3);
    m3_reg = m3;
    sck_o = m3;
    half();
    cs_n_o = 1'b0;
    half();
  endtask
  task automatic stop();
    half();
    sck_o = m3_reg;
    half();
    cs_n_o = 1'b1;
    oe0_o = 1'b0;
    oe1_o = 1'b0;
    half();
    half();
  endtask
  // Sampled late in the high half: the answer lags the falling edge
  task automatic xfer(input logic [7:0] tx, input int w, input logic drv, output logic [7:0] rx);
    for (int i = 7; i >= 0; i -= w)
    begin
      sck_o = 1'b0;
      oe0_o = drv;
      oe1_o = drv && w == 2;
      d1_o = tx[i];
      d0_o = tx[i - w + 1];
      half();
      sck_o = 1'b1;
      half();
      rx[i] = (w == 2) ? line0_i : line1_i;
      if (w == 2)
        rx[i - 1] = line1_i;
    end
  endtask
endmodule

/* File: verification/tb_serial_flash_command_port.sv */
// Testbench for the serial flash command port
`timescale 1ns/1ps
module tb_serial_flash_command_port;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
  localparam logic [15:0] DEV = 16'h7E21; // Arbitrary value
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic busy_i = 1'b0;
  logic prog_ready_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic hold_n_i = 1'b1;
  logic tgl = 1'b0;
  logic [7:0] rx;
  int n_fail = 0;
  int check_count = 0;
  int n_small = 0;
  wire sck_i, cs_n_i, h_d0, h_d1, h_oe0, h_oe1, data_line_zero_i, data_line_one_i;
  wire data_line_zero_o, data_line_zero_oe_o, data_line_one_o, data_line_one_oe_o, mem_rd_o;
  wire small_erase_o, sector_erase_o, chip_erase_o, prog_valid_o, prog_overflow_o;
  wire selected_o, spi_mode3_o, power_down_o;
  wire [7:0] program_data_bytes_o, status_o, mem_rdata_i;
  wire [18:0] mem_addr_o;
  // Undriven lines wander so a stale value never passes
  assign data_line_zero_i = data_line_zero_oe_o ? data_line_zero_o : (h_oe0 ? h_d0 : tgl);
  assign data_line_one_i = data_line_one_oe_o ? data_line_one_o : (h_oe1 ? h_d1 : tgl);
  assign mem_rdata_i = mem_addr_o[7:0] + mem_addr_o[18:11];
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    tgl <= ~tgl;
    n_small <= n_small + small_erase_o + 2 * sector_erase_o + 4 * chip_erase_o;
  end
  flash_host i_flash_host (.sys_clk_i, .line0_i(data_line_zero_i), .line1_i(data_line_one_i),
    .sck_o(sck_i), .cs_n_o(cs_n_i), .d0_o(h_d0), .d1_o(h_d1), .oe0_o(h_oe0), .oe1_o(h_oe1));
  serial_flash_command_port #(.MFR_ID(MFR), .DEV_ID(DEV)) i_serial_flash_command_port (
    .sys_clk_i, .sys_rst_i, .sck_i, .cs_n_i, .data_line_zero_i, .data_line_zero_o,
    .data_line_zero_oe_o, .data_line_one_i, .data_line_one_o, .data_line_one_oe_o, .wp_n_i,
    .hold_n_i, .busy_i, .mem_rdata_i, .mem_rd_o, .mem_addr_o, .small_erase_o, .sector_erase_o,
    .chip_erase_o, .program_data_bytes_o, .prog_valid_o, .prog_ready_i, .prog_overflow_o,
    .selected_o, .spi_mode3_o, .power_down_o, .status_o);
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  function automatic logic [7:0] memv(input logic [18:0] a);
    return a[7:0] + a[18:11];
  endfunction
  task automatic op(input logic [7:0] c, input logic m = 1'b0);
    i_flash_host.start(m);
    i_flash_host.xfer(c, 1, 1'b1, rx);
  endtask
  task automatic tx(input logic [7:0] b, input int w = 1, input logic drv = 1'b1);
    i_flash_host.xfer(b, w, drv, rx);
  endtask
  task automatic adr(input logic [23:0] a, input int w = 1);
    tx(a[23:16], w);
    tx(a[15:8], w);
    tx(a[7:0], w);
  endtask
  task automatic rd(input string what, input logic [7:0] exp, input int w = 1);
    tx(8'h00, w, 1'b0);
    chk(what, exp, rx);
  endtask
  task automatic wen();
    op(8'h06);
    i_flash_host.stop();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reads();
    busy_i = 1'b1;
    op(8'h05);
    rd("status", 8'h01);
    i_flash_host.stop();
    busy_i = 1'b0;
    op(8'h03);
    chk1("mode", 1'b0, spi_mode3_o);
    adr(24'hFFFFFE);
    rd("read", memv(19'h7FFFE));
    rd("read top", memv(19'h7FFFF));
    rd("read wrap", memv(19'h00000));
    i_flash_host.stop();
    op(8'h0B, 1'b1);
    chk1("mode", 1'b1, spi_mode3_o);
    adr(24'h000010);
    tx(8'hA5);
    rd("fast read", memv(19'h00010));
    i_flash_host.stop();
    op(8'h3B);
    adr(24'h012345);
    tx(8'h00, 1, 1'b0);
    rd("dual read", memv(19'h12345), 2);
    chk1("line zero driven", 1'b1, data_line_zero_oe_o);
    rd("dual read next", memv(19'h12346), 2);
    i_flash_host.stop();
    op(8'hBB);
    adr(24'h02ABCD, 2);
    tx(8'h00, 2, 1'b0);
    rd("dual io read", memv(19'h2ABCD), 2);
    i_flash_host.stop();
  endtask
  task automatic t_writes();
    logic [7:0] codes [5] = '{8'h20, 8'hD7, 8'hD8, 8'h60, 8'hC7};
    wen();
    chk1("write enable", 1'b1, status_o[1]);
    op(8'h04);
    i_flash_host.stop();
    chk1("write disable", 1'b0, status_o[1]);
    op(8'h20);
    adr(24'h001000);
    i_flash_host.stop();
    foreach (codes[k])
    begin
      wen();
      op(codes[k]);
      if (k < 3)
        adr(24'h001000);
      i_flash_host.stop();
    end
    chk("erase pulses", 8'h0C, n_small[7:0]);
    wen();
    op(8'h01);
    tx(8'h9C);
    i_flash_host.stop();
    chk("status write", 8'h9C, status_o);
    wp_n_i = 1'b0;
    wen();
    op(8'h01);
    tx(8'h00);
    i_flash_host.stop();
    chk("locked status", 8'h27, {2'h0, status_o[7:2]});
    wp_n_i = 1'b1;
    wen();
    op(8'h01);
    tx(8'h00);
    i_flash_host.stop();
    chk("unlocked status", 8'h00, status_o);
  endtask
  task automatic t_prog();
    int k;
    wen();
    op(8'h02);
    adr(24'h000100);
    for (k = 0; k < 34; k++)
      tx(8'h40 + k[7:0]);
    i_flash_host.stop();
    chk1("overflow", 1'b1, prog_overflow_o);
    prog_ready_i = 1'b1;
    k = 0;
    repeat (40)
    begin
      if (prog_valid_o === 1'b1)
      begin
        chk("program byte", 8'h40 + k[7:0], program_data_bytes_o);
        k++;
      end
      @(negedge sys_clk_i);
    end
    prog_ready_i = 1'b0;
    chk("program count", 8'h20, k[7:0]);
  endtask
  task automatic t_misc();
    op(8'h9F);
    rd("maker id", MFR);
    hold_n_i = 1'b0;
    i_flash_host.half();
    tx(8'h00, 1, 1'b0);
    chk1("held output", 1'b0, data_line_one_oe_o);
    hold_n_i = 1'b1;
    i_flash_host.half();
    rd("device id high", DEV[15:8]);
    rd("device id low", DEV[7:0]);
    i_flash_host.stop();
    op(8'hB9);
    i_flash_host.stop();
    chk1("power down", 1'b1, power_down_o);
    op(8'h05);
    tx(8'h00, 1, 1'b0);
    chk1("asleep output", 1'b0, data_line_one_oe_o);
    i_flash_host.stop();
    op(8'hAB);
    adr(24'h000000);
    rd("wake id", DEV[7:0]);
    i_flash_host.stop();
    chk1("awake", 1'b0, power_down_o);
    op(8'h03);
    tx(8'h12);
    i_flash_host.stop();
    op(8'hFF);
    tx(8'h00, 1, 1'b0);
    chk1("unknown opcode output", 1'b0, data_line_one_oe_o);
    i_flash_host.stop();
    op(8'h05);
    rd("status after abort", 8'h00);
    i_flash_host.stop();
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (3) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    t_reads();
    t_writes();
    t_prog();
    t_misc();
    final_report();
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk_i);
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
endmodule
